// ==== logic/tlic_core.sv ====
// two-level interrupt controller: pending, enables, priorities, nesting and vectored calls
// ****************************************
// How it works
// - pending bits read one while pending; writing zero clears that bit
// - pending layout: capture 5, motion 4, fault 2, align 1, external two 0
// - pending bits 7 and 6 always read zero
// - pending indication clears itself when its service call is issued
// - two levels only, taken solely from the priority registers
// - non-maskable request has no level and beats every other request
// - low priority register: timers, serial and externals in bits 5..0
// - high priority register: extended sources, bit 3 reserved, 7..6 zero
// - service is pre-empted only by a strictly higher level
// - simultaneous different levels: high level served first
// - equal level: fixed order non-maskable, then slot 0 up to slot 11
// - request to service start takes three to nine clocks
// - service issues a long call to the source's own vector
// - vector is 0003 hex plus eight per slot, non-maskable at 0073
// - global enable low blocks maskable sources; else per-source enables gate
// - extended sources except external two are active-low levels
// ****************************************
`timescale 1ns/1ns
`default_nettype none
`include "tlic_map.svh"
module tlic_core (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic external_request_zero,
	input wire logic timer_zero_overflow,
	input wire logic external_request_one,
	input wire logic timer_one_overflow,
	input wire logic serial_port_request,
	input wire logic timer_two_overflow,
	input wire logic external_request_two_n,
	input wire logic cycle_align_request_n,
	input wire logic fault_request_n,
	input wire logic motion_engine_request_n,
	input wire logic capture_timer_request_n,
	input wire logic nmi_request,
	input wire logic instr_end,
	input wire logic isr_return,
	output logic call_req,
	output logic [15:0] call_vector,
	output tlic_pkg::tlic_vec_t service_ack,
	output logic irq
);
	import tlic_pkg::*;
	typedef struct packed {
		logic [7:0] enable_mask_low;
		logic [7:0] enable_mask_high;
		logic [7:0] priority_select_low;
		logic [7:0] priority_select_high;
		logic [5:0] pending;
		logic nmi_pend;
		logic ext2_prev;
		tlic_state_t state;
		logic act_lo;
		logic act_hi;
		logic act_nmi;
		logic [7:0] rdata;
		logic call;
		logic [15:0] vector;
		tlic_vec_t ack;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
	} tlic_regs_t;
	tlic_regs_t r_reg;
	tlic_regs_t r_next;
	logic ext2_level;
	logic [5:0] ext_active;
	logic [14:0] req;
	logic [14:0] hi_level;
	logic arb_valid;
	tlic_slot_t arb_slot;
	logic arb_hi;
	logic arb_nmi;
	logic global_en;
	// ****************************************
	// pin synchroniser for external two
	// ****************************************
	// the pin is the only input from outside the clock domain; the other sources
	// come from blocks on this clock and are used as they arrive
	tlic_sync3 u_ext2_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pin_in(external_request_two_n),
		.level_out(ext2_level)
	);
	// ****************************************
	// request vector
	// ****************************************
	// extended events in pending-register order; bit 3 has no source
	// level sources raise their bit on every low cycle, the pin only on a fall,
	// so a pin held low after service does not call a second time
	always_comb begin
		ext_active = 6'h00;
		ext_active[0] = r_reg.ext2_prev && !ext2_level; // falling edge of the pin
		ext_active[1] = !cycle_align_request_n;
		ext_active[2] = !fault_request_n;
		ext_active[4] = !motion_engine_request_n;
		ext_active[5] = !capture_timer_request_n;
	end
	assign global_en = r_reg.enable_mask_low[`TLIC_GLOBAL_EN_BIT];
	// gate every maskable slot, non-maskable always passes
	// masking acts on the request, never on the pending bit, so a masked event
	// is still waiting once software enables it
	always_comb begin
		req = 15'h0000;
		hi_level = 15'h0000;
		req[0] = external_request_zero;
		req[1] = timer_zero_overflow;
		req[2] = external_request_one;
		req[3] = timer_one_overflow;
		req[4] = serial_port_request;
		req[5] = timer_two_overflow;
		req[5:0] = req[5:0] & r_reg.enable_mask_low[5:0] & {6{global_en}};
		req[11:6] = r_reg.pending & r_reg.enable_mask_high[5:0] & {6{global_en}};
		req[`TLIC_NMI_SLOT] = r_reg.nmi_pend;
		hi_level[5:0] = r_reg.priority_select_low[5:0];
		hi_level[11:6] = r_reg.priority_select_high[5:0];
	end
	// ****************************************
	// arbitration
	// ****************************************
	// the arbiter applies nesting and polling order
	// it is purely combinational; the service state machine uses its valid flag in idle and arbitration,
	// and its slot and level only on the cycle that issues the call
	tlic_arbiter u_arbiter (
		.req(req),
		.hi_level(hi_level),
		.act_lo(r_reg.act_lo),
		.act_hi(r_reg.act_hi),
		.act_nmi(r_reg.act_nmi),
		.valid(arb_valid),
		.slot(arb_slot),
		.is_hi(arb_hi),
		.is_nmi(arb_nmi)
	);
	// ****************************************
	// issue decode
	// ****************************************
	// vector and pending index of the current winner, used on the issuing edge
	logic [15:0] win_vector;
	logic [2:0] win_ext_index;
	logic win_is_ext;
	always_comb begin
		win_vector = `TLIC_VEC_BASE + {9'h000, arb_slot, 3'h0};
		win_is_ext = (arb_slot >= 4'(`TLIC_EXT_BASE_SLOT)) && !arb_nmi;
		win_ext_index = 3'(arb_slot - 4'(`TLIC_EXT_BASE_SLOT));
	end
	// ****************************************
	// next state
	// ****************************************
	// one pass over the whole state: bus writes first, then service clears,
	// then hardware sets, so that a set in the same cycle always survives;
	// the same order gives the event flags their set-wins behaviour
	always_comb begin
		r_next = r_reg;
		r_next.rdata = 8'h00;
		r_next.call = 1'b0;
		r_next.ack = 15'h0000;
		r_next.ext2_prev = ext2_level;
		// register writes; unmapped places fall through and change nothing
		if (reg_write) begin
			case (reg_addr)
				// global enable in bit 7, bit 6 has no storage
				`TLIC_OFF_ENABLE_LOW: begin
					r_next.enable_mask_low = reg_wdata & `TLIC_ENABLE_LOW_MASK;
				end
				// extended enables, bit 3 reserved
				`TLIC_OFF_ENABLE_HIGH: begin
					r_next.enable_mask_high = reg_wdata & `TLIC_HIGH_MASK;
				end
				// standard slot levels
				`TLIC_OFF_PRIO_LOW: begin
					r_next.priority_select_low = reg_wdata & `TLIC_LOW_MASK;
				end
				// extended slot levels
				`TLIC_OFF_PRIO_HIGH: begin
					r_next.priority_select_high = reg_wdata & `TLIC_HIGH_MASK;
				end
				// a zero clears, a one leaves the bit as it is
				`TLIC_OFF_PENDING: begin
					r_next.pending = r_reg.pending & reg_wdata[5:0];
				end
				// event flags clear on a one
				`TLIC_OFF_IRQ_STATUS: begin
					r_next.irq_status = r_reg.irq_status & ~reg_wdata[2:0];
				end
				// flags that may drive the interrupt line
				`TLIC_OFF_IRQ_MASK: begin
					r_next.irq_mask = reg_wdata[2:0];
				end
				default: begin
				end
			endcase
		end
		// register reads, data in the following cycle and zero otherwise
		// a write and a read may come on back-to-back cycles, never together
		if (reg_read) begin
			case (reg_addr)
				// bit 6 reads zero as it is never stored
				`TLIC_OFF_ENABLE_LOW: begin
					r_next.rdata = r_reg.enable_mask_low;
				end
				// reserved bits read zero
				`TLIC_OFF_ENABLE_HIGH: begin
					r_next.rdata = r_reg.enable_mask_high;
				end
				// read-only bits read zero
				`TLIC_OFF_PRIO_LOW: begin
					r_next.rdata = r_reg.priority_select_low;
				end
				// reserved and unimplemented bits read zero
				`TLIC_OFF_PRIO_HIGH: begin
					r_next.rdata = r_reg.priority_select_high;
				end
				// pending copy, reserved places forced to zero
				`TLIC_OFF_PENDING: begin
					r_next.rdata = {2'h0, r_reg.pending & `TLIC_PEND_MASK};
				end
				// event flags
				`TLIC_OFF_IRQ_STATUS: begin
					r_next.rdata = {5'h00, r_reg.irq_status};
				end
				// event mask
				`TLIC_OFF_IRQ_MASK: begin
					r_next.rdata = {5'h00, r_reg.irq_mask};
				end
				// an unmapped place reads as zero
				default: begin
					r_next.rdata = 8'h00;
				end
			endcase
		end
		// service state machine
		// idle sees a winner, arbitration waits for the end of an instruction,
		// and the call state gives one quiet cycle before the next decision
		case (r_reg.state)
			ST_IDLE: begin
				if (arb_valid) begin
					r_next.state = ST_ARB;
				end
			end
			ST_ARB: begin
				// winner is re-evaluated until the core reaches an instruction end
				// so a stronger request that arrives meanwhile overtakes the first
				if (!arb_valid) begin
					r_next.state = ST_IDLE;
				end else if (instr_end) begin
					r_next.state = ST_CALL;
					r_next.call = 1'b1;
					r_next.vector = win_vector;
					// the acknowledge tells a standard source to drop its request
					r_next.ack[arb_slot] = 1'b1;
					if (win_is_ext) begin
						r_next.pending[win_ext_index] = 1'b0;
					end
					// open the level of the winner; the non-maskable one is flagged too
					if (arb_nmi) begin
						r_next.nmi_pend = 1'b0;
						r_next.act_nmi = 1'b1;
						r_next.irq_status[`TLIC_STAT_NMI] = 1'b1;
					end else if (arb_hi) begin
						r_next.act_hi = 1'b1;
					end else begin
						r_next.act_lo = 1'b1;
					end
					// a call while a level is open is a nesting step
					if (r_reg.act_lo || r_reg.act_hi) begin
						r_next.irq_status[`TLIC_STAT_PREEMPT] = 1'b1;
					end
					r_next.irq_status[`TLIC_STAT_CALL] = 1'b1;
				end
			end
			ST_CALL: begin
				// one quiet cycle, so calls stand at least three cycles apart
				r_next.state = ST_IDLE;
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase
		// return from service closes the innermost level
		// the level is picked from the state before any call of this cycle,
		// so a call and a return on one edge both take effect
		if (isr_return) begin
			if (r_reg.act_nmi) begin
				r_next.act_nmi = 1'b0;
			end else if (r_reg.act_hi) begin
				r_next.act_hi = 1'b0;
			end else begin
				r_next.act_lo = 1'b0;
			end
		end
		// hardware sets win over software and service clears
		// a level source still low after its service sets its bit again here
		r_next.pending = r_next.pending | ext_active;
		if (nmi_request) begin
			r_next.nmi_pend = 1'b1;
		end
	end
	// ****************************************
	// registers
	// ****************************************
	// synchronous reset; the edge detector starts at the idle-high pin level
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			// software registers
			r_reg.enable_mask_low <= `TLIC_RST_BYTE;
			r_reg.enable_mask_high <= `TLIC_RST_BYTE;
			r_reg.priority_select_low <= `TLIC_RST_BYTE;
			r_reg.priority_select_high <= `TLIC_RST_BYTE;
			r_reg.pending <= `TLIC_RST_PEND;
			r_reg.nmi_pend <= 1'b0;
			r_reg.ext2_prev <= 1'b1;
			// service tracking
			r_reg.state <= ST_IDLE;
			r_reg.act_lo <= 1'b0;
			r_reg.act_hi <= 1'b0;
			r_reg.act_nmi <= 1'b0;
			// registered outputs
			r_reg.rdata <= `TLIC_RST_BYTE;
			r_reg.call <= 1'b0;
			r_reg.vector <= `TLIC_RST_VEC;
			r_reg.ack <= `TLIC_RST_ACK;
			r_reg.irq_status <= `TLIC_RST_STAT;
			r_reg.irq_mask <= `TLIC_RST_STAT;
		end else begin
			r_reg <= r_next;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	// every output but the interrupt line is a register bit, so the core sees no glitch
	assign reg_rdata = r_reg.rdata;
	assign call_req = r_reg.call;
	assign call_vector = r_reg.vector;
	assign service_ack = r_reg.ack;
	assign irq = |(r_reg.irq_status & r_reg.irq_mask); // level interrupt line
endmodule
`default_nettype wire

// ==== logic/tlic_map.svh ====
// register offsets, field positions, reset values and vectors of the interrupt controller
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define TLIC_OFF_ENABLE_LOW 8'hA8
`define TLIC_OFF_PRIO_LOW 8'hB8
`define TLIC_OFF_PENDING 8'hC0
`define TLIC_OFF_ENABLE_HIGH 8'hE8
`define TLIC_OFF_PRIO_HIGH 8'hF8
`define TLIC_OFF_IRQ_STATUS 8'hD8
`define TLIC_OFF_IRQ_MASK 8'hD9
// ****************************************
// field layout
// ****************************************
`define TLIC_GLOBAL_EN_BIT 7
`define TLIC_LOW_MASK 8'h3F
`define TLIC_HIGH_MASK 8'h37
`define TLIC_ENABLE_LOW_MASK 8'hBF
`define TLIC_PEND_MASK 6'h37
`define TLIC_EXT_BASE_SLOT 6
`define TLIC_NMI_SLOT 14
`define TLIC_NUM_SLOTS 15
`define TLIC_STAT_CALL 0
`define TLIC_STAT_NMI 1
`define TLIC_STAT_PREEMPT 2
// ****************************************
// reset values and vectors
// ****************************************
`define TLIC_RST_BYTE 8'h00
`define TLIC_RST_STAT 3'h0
`define TLIC_RST_PEND 6'h00
`define TLIC_RST_VEC 16'h0000
`define TLIC_RST_ACK 15'h0000
`define TLIC_VEC_BASE 16'h0003
`define TLIC_VEC_STEP 16'h0008
`endif

// ==== logic/tlic_pkg.sv ====
// types shared by the interrupt controller modules
package tlic_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARB = 2'b01,
		ST_CALL = 2'b11
	} tlic_state_t;
	typedef logic [3:0] tlic_slot_t;
	typedef logic [14:0] tlic_vec_t;
endpackage

// ==== logic/tlic_sync3.sv ====
// three-flop pin synchroniser whose output moves once the last two stages agree
`timescale 1ns/1ns
`default_nettype none
module tlic_sync3 (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pin_in,
	output logic level_out
);
	import tlic_pkg::*;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} tlic_sync_t;
	tlic_sync_t st_reg;
	tlic_sync_t st_next;
	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.level = st_reg.s3;
		end
	end
	// registers; pin idles high
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end
	assign level_out = st_reg.level;
endmodule
`default_nettype wire

// ==== logic/tlic_arbiter.sv ====
// picks the request to service from levels, nesting state and fixed polling order
`timescale 1ns/1ns
`default_nettype none
`include "tlic_map.svh"
module tlic_arbiter (
	input wire logic [14:0] req,
	input wire logic [14:0] hi_level,
	input wire logic act_lo,
	input wire logic act_hi,
	input wire logic act_nmi,
	output logic valid,
	output tlic_pkg::tlic_slot_t slot,
	output logic is_hi,
	output logic is_nmi
);
	import tlic_pkg::*;
	// ****************************************
	// selection
	// ****************************************
	always_comb begin
		valid = 1'b0;
		slot = '0;
		is_hi = 1'b0;
		is_nmi = 1'b0;
		// lowest slot number wins inside a level
		if (!act_hi && !act_nmi) begin
			for (int i = 13; i >= 0; i--) begin
				if (req[i] && hi_level[i]) begin
					valid = 1'b1;
					slot = 4'(i);
					is_hi = 1'b1;
				end
			end
		end
		// low level only when nothing is in service and no high request
		if (!valid && !act_lo && !act_hi && !act_nmi) begin
			for (int i = 13; i >= 0; i--) begin
				if (req[i] && !hi_level[i]) begin
					valid = 1'b1;
					slot = 4'(i);
				end
			end
		end
		// non-maskable beats everything
		if (req[`TLIC_NMI_SLOT] && !act_nmi) begin
			valid = 1'b1;
			slot = 4'(`TLIC_NMI_SLOT);
			is_hi = 1'b0;
			is_nmi = 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tlic_src_model.sv ====
// far-side model: core instruction timing, service returns, standard slot sources
`timescale 1ns/1ns
`default_nettype none
module tlic_src_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic ret_cmd,
	input wire logic [5:0] raise,
	input wire tlic_pkg::tlic_vec_t service_ack,
	output logic [5:0] std_req,
	output logic instr_end,
	output logic isr_return
);
	import tlic_pkg::*;
	logic [1:0] phase_reg;
	// sources hold their level until acknowledged, so one call per raise
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
			std_req <= 6'h00;
			isr_return <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			std_req <= (std_req | raise) & ~service_ack[5:0];
			isr_return <= ret_cmd;
		end
	end
	// slow core ends an instruction every fourth clock only
	assign instr_end = slow ? (phase_reg == 2'h0) : 1'b1;
endmodule
`default_nettype wire

// ==== verif/tlic_core_chk.sv ====
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
`default_nettype none
module tlic_core_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic instr_end,
	input wire logic nmi_request,
	input wire logic call_req,
	input wire logic [15:0] call_vector,
	input wire tlic_pkg::tlic_vec_t service_ack
);
	import tlic_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// expected vector of a one-hot acknowledge
	function automatic logic [15:0] vec_of(input tlic_vec_t a);
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 0; i < 15; i++) begin
			if (a[i]) begin
				v = 16'h0003 + 16'h0008 * 16'(i);
			end
		end
		return v;
	endfunction
	sequence s_nmi_raise;
		$rose(nmi_request);
	endsequence
	sequence s_nmi_call;
		call_req && service_ack[14];
	endsequence
	a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_pend_rsvd: assert property (reg_read && reg_addr == 8'hC0 |=> (reg_rdata & 8'hC8) == 8'h00)
		else $error("pending reserved bits not zero");
	a_prio_low_rsvd: assert property (reg_read && reg_addr == 8'hB8 |=> reg_rdata[7:6] == 2'h0)
		else $error("low priority bits 7..6 not zero");
	a_prio_high_rsvd: assert property (reg_read && reg_addr == 8'hF8 |=> (reg_rdata & 8'hC8) == 8'h00)
		else $error("high priority reserved bits not zero");
	a_call_gap: assert property (call_req |=> !call_req ##1 !call_req)
		else $error("calls too close");
	a_ack_onehot: assert property (call_req |-> $onehot(service_ack))
		else $error("acknowledge not one-hot at call");
	a_ack_alone: assert property (service_ack != 15'h0000 |-> call_req)
		else $error("acknowledge without call");
	a_vec_map: assert property (call_req |-> call_vector == vec_of(service_ack))
		else $error("vector does not match serviced source");
	a_call_at_end: assert property (call_req |-> $past(instr_end))
		else $error("call issued off an instruction end");
	a_vec_hold: assert property (!call_req |-> $stable(call_vector))
		else $error("vector moved without a call");
	a_nmi_latency: assert property (s_nmi_raise |-> ##[3:9] s_nmi_call)
		else $error("non-maskable request not serviced in time");
endmodule
bind tlic_core tlic_core_chk tlic_core_chk_inst (.clock(clock), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_end(instr_end),
	.nmi_request(nmi_request), .call_req(call_req), .call_vector(call_vector),
	.service_ack(service_ack));
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking testbench of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	import tlic_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [4:0] ext_n = 5'h1F;
	logic nmi_request = 1'b0, slow = 1'b0, ret_cmd = 1'b0, instr_end, isr_return, call_req, irq;
	logic [5:0] raise = 6'h00, std_req;
	logic [15:0] call_vector;
	tlic_vec_t service_ack;
	logic [15:0] seen [$];
	int mismatches = 0, checks = 0;
	logic [7:0] ra [7] = '{8'hA8, 8'hE8, 8'hB8, 8'hF8, 8'hC0, 8'hD8, 8'hD9};
	logic [7:0] rm [7] = '{8'hBF, 8'h37, 8'h3F, 8'h37, 8'h00, 8'h00, 8'h07};
	always #10 clock = ~clock;
	tlic_core tlic_core_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.external_request_zero(std_req[0]), .timer_zero_overflow(std_req[1]),
		.external_request_one(std_req[2]), .timer_one_overflow(std_req[3]),
		.serial_port_request(std_req[4]), .timer_two_overflow(std_req[5]),
		.external_request_two_n(ext_n[0]), .cycle_align_request_n(ext_n[1]),
		.fault_request_n(ext_n[2]), .motion_engine_request_n(ext_n[3]),
		.capture_timer_request_n(ext_n[4]), .nmi_request(nmi_request), .instr_end(instr_end),
		.isr_return(isr_return), .call_req(call_req), .call_vector(call_vector),
		.service_ack(service_ack), .irq(irq));
	tlic_src_model tlic_src_model_inst (.clock(clock), .rst_n(rst_n), .slow(slow),
		.ret_cmd(ret_cmd), .raise(raise), .service_ack(service_ack), .std_req(std_req),
		.instr_end(instr_end), .isr_return(isr_return));
	// record every issued call vector
	always @(posedge clock) begin
		if (call_req === 1'b1) begin
			seen.push_back(call_vector);
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask
	// drive chosen active-low sources low for n clocks
	task automatic lo(input logic [4:0] m, input int n);
		@(posedge clock);
		ext_n <= ~m;
		repeat (n) @(posedge clock);
		ext_n <= 5'h1F;
	endtask
	task automatic ret;
		@(posedge clock);
		ret_cmd <= 1'b1;
		@(posedge clock);
		ret_cmd <= 1'b0;
	endtask
	task automatic want_call(input logic [15:0] v);
		int n;
		n = 0;
		while (seen.size() == 0 && n < 16) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("call_vector", v, (seen.size() == 0) ? 16'hFFFF : seen.pop_front());
	endtask
	task automatic no_call;
		repeat (12) @(posedge clock);
		#1;
		chk("call count", 16'h0000, 16'(seen.size()));
	endtask
	task automatic stop_test;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#400000;
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		// reset values, writable bits, unmapped place
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], 8'h00);
			wr(ra[i], 8'hFF);
			rd(ra[i], rm[i]);
			wr(ra[i], 8'h00);
		end
		wr(8'h55, 8'hFF);
		rd(8'h55, 8'h00);
		// masked sources still set pending
		lo(5'h1F, 3);
		no_call();
		rd(8'hC0, 8'h37);
		wr(8'hC0, 8'h35);
		rd(8'hC0, 8'h35);
		wr(8'hC0, 8'h14);
		rd(8'hC0, 8'h14);
		wr(8'hA8, 8'hA1);
		wr(8'hE8, 8'h37);
		want_call(16'h0043);
		rd(8'hC0, 8'h10);
		no_call();
		ret();
		want_call(16'h0053);
		ret();
		// high level first, preemption, non-maskable on top
		wr(8'hF8, 8'h10);
		lo(5'h0C, 1);
		want_call(16'h0053);
		no_call();
		ret();
		want_call(16'h0043);
		lo(5'h08, 1);
		want_call(16'h0053);
		@(posedge clock);
		nmi_request <= 1'b1;
		@(posedge clock);
		nmi_request <= 1'b0;
		want_call(16'h0073);
		rd(8'hD8, 8'h07);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(8'hD9, 8'h01);
		#1;
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(8'hD8, 8'h07);
		rd(8'hD8, 8'h00);
		chk("irq", 16'h0000, {15'h0000, irq});
		repeat (3) ret();
		// standard slots on a slow core
		slow <= 1'b1;
		wr(8'hB8, 8'h20);
		@(posedge clock);
		raise <= 6'h21;
		@(posedge clock);
		raise <= 6'h00;
		want_call(16'h002B);
		ret();
		want_call(16'h0003);
		ret();
		no_call();
		stop_test();
	end
endmodule
`default_nettype wire
